// file: hdl/sync_serial_pkg.sv
// constants and carriers for the serial port clock generator and status
// assumes a 32-bit Avalon-MM slave with one register per aligned word
package sync_serial_pkg;
	localparam logic [4:0] OFS_RELOAD = 5'h00;
	localparam logic [4:0] OFS_BUFFER = 5'h04;
	localparam logic [4:0] OFS_CTRL1  = 5'h08;
	localparam logic [4:0] OFS_CTRL2  = 5'h0C;
	localparam logic [4:0] OFS_CTRL3  = 5'h10;
	localparam logic [4:0] OFS_MASK   = 5'h14;
	localparam logic [4:0] OFS_STATUS = 5'h18;
	localparam logic [4:0] OFS_FLAGS  = 5'h1C;
	localparam int C1_WRITE_COLLISION  = 7;
	localparam int C1_EN    = 5;
	localparam int C2_STAT  = 6;
	localparam int C2_ACK_SEQUENCE_ENABLE = 4;
	localparam int C2_RECEIVE_ENABLE  = 3;
	localparam int C2_PEN   = 2;
	localparam int C2_RESTART_ENABLE  = 1;
	localparam int C2_SEN   = 0;
	localparam int ST_SMP   = 7;
	localparam int ST_CKE   = 6;
	localparam int FL_PORT  = 0;
	localparam int FL_COLL  = 1;
	localparam logic [3:0] MODE_MASTER = 4'h8;
	localparam logic [3:0] MODE_SLV10  = 4'h7;
	localparam logic [3:0] MODE_SLV10S = 4'hF;
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam logic [3:0] TX_BITS     = 4'h9;
	localparam logic [3:0] RX_BITS     = 4'h8;
	typedef struct packed {
		logic scl_out;
		logic scl_oe_n;
		logic sda_out;
		logic sda_oe_n;
	} pad_out_t;
	typedef struct packed {
		logic slew_limit_en;
		logic smbus_levels;
		logic spi_sample_end;
		logic spi_tx_idle_edge;
	} pin_cfg_t;
endpackage

// file: hdl/sync_serial_port.sv
// serial port master: baud generator, stop sequence, status register
// assumes scl_in/sda_in already synchronous to ref_clk; open-drain pads
// Summary of operation
// - after releasing SDA and count expiry, SDA low means bus collision
// - SCL low before SDA goes high during stop means bus collision
// - stop drives SDA low, releases SCL, loads generator when SCL high
// - buffer write starts the generator counting from twice the reload value plus one
// - when an operation ends the generator stops, SCL keeps its level
// - generator reloads twice per serial clock period
// - status bit 7 picks SPI sample point; cleared by software in slave
// - in I2C status bit 7 disables slew limiting when one
// - in SPI status bit 6 selects transmit clock edge
// - in I2C status bit 6 selects SMBus input thresholds
// - status bit 5 shows last byte was data, zero for address
// - status bit 4 shows stop seen last; cleared by reset or disable
// - status bit 3 shows start seen last; cleared by reset or disable
// - in slave mode bit 2 holds captured direction until start, stop or a sent byte left unacknowledged
// - in master mode bit 2 shows transmit busy; busy ORs enable bits
// - status bit 1 asks software for a new address in 10-bit mode
// - buffer full set when a reception completes
// - on transmit buffer full holds during data bits only
// - clean stop releases SDA, sets stop seen, then clears enable, sets irq
// - collision sets flag, releases lines, aborts stop, goes idle
// - buffer write during a stop sets write collision, data kept
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module sync_serial_port (
	input  wire logic                      ref_clk,
	input  wire logic                      reset_n,
	input  wire logic [4:0]                avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [31:0]               avs_writedata,
	output logic [31:0]                    avs_readdata,
	output logic                           avs_waitrequest,
	input  wire logic                      scl_in,
	input  wire logic                      sda_in,
	output sync_serial_pkg::pad_out_t      pads,
	output sync_serial_pkg::pin_cfg_t      pin_cfg,
	output logic                           port_busy
);
	import sync_serial_pkg::*;

	typedef enum logic [3:0] {
		S_IDLE, S_BIT_LOW, S_BIT_WAIT, S_BIT_HIGH,
		S_STP_SDA, S_STP_LOW, S_STP_SCL, S_STP_HIGH, S_STP_REL, S_STP_END
	} state_t;

	function automatic logic [8:0] phase_len(input logic [7:0] rv);
		phase_len = {rv, 1'b1};
	endfunction

	state_t      state_ff;
	state_t      nxt_state;
	logic        ack_ff;
	logic [7:0]  reload_ff;
	logic [7:0]  buffer_ff;
	logic [5:0]  ctrl1_ff;
	logic        write_collision_ff;
	logic [7:0]  ctrl2_ff;
	logic [7:0]  ctrl3_ff;
	logic [7:0]  mask_ff;
	logic [1:0]  cfg_ff;
	logic        data_ff;
	logic        stop_seen_ff;
	logic        start_seen_ff;
	logic        rw_ff;
	logic        ua_ff;
	logic        full_ff;
	logic        tx_busy_ff;
	logic        first_ff;
	logic [1:0]  irq_ff;
	logic [8:0]  cnt_ff;
	logic        run_ff;
	logic        scl_low_ff;
	logic        sda_low_ff;
	logic        scl_q_ff;
	logic        sda_q_ff;
	logic [7:0]  shift_ff;
	logic [3:0]  bits_ff;
	logic        rx_ff;
	logic [31:0] rd_mux;

	// one wait cycle per access: the answer comes at the second edge
	wire wr      = avs_write & ack_ff;
	wire wr_rel  = wr & (avs_address == OFS_RELOAD);
	wire wr_buf  = wr & (avs_address == OFS_BUFFER);
	wire wr_c1   = wr & (avs_address == OFS_CTRL1);
	wire wr_c2   = wr & (avs_address == OFS_CTRL2);
	wire wr_c3   = wr & (avs_address == OFS_CTRL3);
	wire wr_msk  = wr & (avs_address == OFS_MASK);
	wire wr_st   = wr & (avs_address == OFS_STATUS);
	wire wr_fl   = wr & (avs_address == OFS_FLAGS);
	wire rd_buf  = avs_read & ack_ff & (avs_address == OFS_BUFFER);
	wire [7:0] wd = avs_writedata[7:0];

	wire en      = ctrl1_ff[C1_EN];
	wire [3:0] mode = ctrl1_ff[3:0];
	wire master  = en & (mode == MODE_MASTER);
	wire i2c     = mode[3] | mode[2] & mode[1];
	wire ten_bit = (mode == MODE_SLV10) | (mode == MODE_SLV10S);
	wire stop_enable     = ctrl2_ff[C2_PEN];
	wire receive_enable    = ctrl2_ff[C2_RECEIVE_ENABLE];
	wire in_stop = (state_ff >= S_STP_SDA);

	wire brg_to   = run_ff & (cnt_ff == 9'h000);
	wire tx_go    = wr_buf & master & (state_ff == S_IDLE) & ~stop_enable;
	wire write_collision_set = wr_buf & ~tx_go;
	wire rx_go    = master & receive_enable & (state_ff == S_IDLE) & ~tx_go;
	wire stp_go   = master & stop_enable & (state_ff == S_IDLE) & ~tx_go & ~rx_go;
	wire last_bit = (bits_ff == 4'h1);
	wire ack_next = ~rx_ff & (bits_ff == 4'h2);
	wire [7:0] nxt_shift = {shift_ff[6:0], sda_in};
	wire arb_lost = (state_ff == S_BIT_HIGH) & ~rx_ff & ~sda_low_ff
		& ~sda_in & ~last_bit;
	wire coll_scl = (state_ff == S_STP_HIGH) & ~scl_in
		| (state_ff == S_STP_REL) & ~scl_in & ~sda_in;
	wire coll_sda = (state_ff == S_STP_REL) & brg_to & ~sda_in;
	wire coll     = arb_lost | coll_scl | coll_sda;
	wire stop_ok  = (state_ff == S_STP_END) & brg_to;
	wire bit_done = (state_ff == S_BIT_HIGH) & brg_to & ~arb_lost;
	wire tx_done  = bit_done & last_bit & ~rx_ff;
	wire rx_done  = bit_done & last_bit & rx_ff;
	wire start_det = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
	wire stop_det  = scl_in & scl_q_ff & ~sda_q_ff & sda_in;

	// generator loads: once per low phase, once per high phase
	wire brg_load = tx_go | rx_go
		| (state_ff == S_STP_SDA) & ~sda_in
		| (state_ff == S_BIT_WAIT) & scl_in
		| (state_ff == S_STP_SCL) & scl_in
		| (state_ff == S_STP_HIGH) & brg_to & ~coll
		| (state_ff == S_STP_REL) & brg_to & ~coll
		| bit_done & ~last_bit;
	wire brg_stop = brg_to & ~brg_load;
	// the cycle that sees SCL high already counts toward the high phase
	wire [8:0] load_val = (state_ff == S_BIT_WAIT)
		? phase_len(reload_ff) - 9'h001 : phase_len(reload_ff);

	assign port_busy = tx_busy_ff | ctrl2_ff[C2_SEN] | ctrl2_ff[C2_RESTART_ENABLE]
		| stop_enable | receive_enable | ctrl2_ff[C2_ACK_SEQUENCE_ENABLE];

	// open drain: output always low, enable low only while pulling down
	assign pads.scl_out  = 1'b0;
	assign pads.sda_out  = 1'b0;
	assign pads.scl_oe_n = ~scl_low_ff;
	assign pads.sda_oe_n = ~sda_low_ff;
	assign pin_cfg.slew_limit_en    = i2c & ~cfg_ff[1];
	assign pin_cfg.smbus_levels     = i2c & cfg_ff[0];
	assign pin_cfg.spi_sample_end   = ~i2c & cfg_ff[1];
	assign pin_cfg.spi_tx_idle_edge = ~i2c & cfg_ff[0];
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE: begin
				if (tx_go | rx_go)
					nxt_state = S_BIT_LOW;
				else if (stp_go)
					nxt_state = S_STP_SDA;
			end
			S_BIT_LOW:  if (brg_to) nxt_state = S_BIT_WAIT;
			S_BIT_WAIT: if (scl_in) nxt_state = S_BIT_HIGH;
			S_BIT_HIGH: begin
				if (brg_to)
					nxt_state = last_bit ? S_IDLE : S_BIT_LOW;
			end
			S_STP_SDA:  if (~sda_in) nxt_state = S_STP_LOW;
			S_STP_LOW:  if (brg_to) nxt_state = S_STP_SCL;
			S_STP_SCL:  if (scl_in) nxt_state = S_STP_HIGH;
			S_STP_HIGH: if (brg_to) nxt_state = S_STP_REL;
			S_STP_REL:  if (brg_to) nxt_state = S_STP_END;
			S_STP_END:  if (brg_to) nxt_state = S_IDLE;
			default:    nxt_state = S_IDLE;
		endcase
		if (coll | ~en)
			nxt_state = S_IDLE;
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (avs_address == OFS_RELOAD)
			rd_mux[7:0] = reload_ff;
		else if (avs_address == OFS_BUFFER)
			rd_mux[7:0] = buffer_ff;
		else if (avs_address == OFS_CTRL1)
			rd_mux[7:0] = {write_collision_ff, 1'b0, ctrl1_ff};
		else if (avs_address == OFS_CTRL2)
			rd_mux[7:0] = ctrl2_ff;
		else if (avs_address == OFS_CTRL3)
			rd_mux[7:0] = ctrl3_ff;
		else if (avs_address == OFS_MASK)
			rd_mux[7:0] = mask_ff;
		else if (avs_address == OFS_STATUS)
			rd_mux[7:0] = {cfg_ff, data_ff, stop_seen_ff, start_seen_ff,
				master ? tx_busy_ff : rw_ff, ua_ff, full_ff};
		else if (avs_address == OFS_FLAGS)
			rd_mux[1:0] = irq_ff;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ack_ff       <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_ff       <= (avs_read | avs_write) & ~ack_ff;
			avs_readdata <= rd_mux;
		end
	end

	// plain software registers; reload values below 3 are not guarded
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			reload_ff <= RST_BYTE;
			ctrl1_ff  <= 6'h00;
			ctrl3_ff  <= RST_BYTE;
			mask_ff   <= RST_BYTE;
			cfg_ff    <= 2'b00;
		end else begin
			if (wr_rel)
				reload_ff <= wd;
			if (wr_c1)
				ctrl1_ff <= wd[5:0];
			if (wr_c3)
				ctrl3_ff <= wd;
			if (wr_msk)
				mask_ff <= wd;
			if (wr_st)
				cfg_ff <= wd[ST_SMP:ST_CKE];
		end
	end

	// write_collision and irq flags: hardware set wins over a software clear
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			write_collision_ff <= 1'b0;
			irq_ff  <= 2'b00;
		end else begin
			write_collision_ff <= write_collision_set | write_collision_ff & ~(wr_c1 & ~wd[C1_WRITE_COLLISION]);
			irq_ff[FL_COLL] <= coll & en
				| irq_ff[FL_COLL] & ~(wr_fl & wd[FL_COLL]);
			irq_ff[FL_PORT] <= stop_ok | tx_done | rx_done
				| irq_ff[FL_PORT] & ~(wr_fl & wd[FL_PORT]);
		end
	end

	// enable bits are refused while the port is busy; hardware clears the stop and receive enables when done, all of them on collision or disable
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			ctrl2_ff <= RST_BYTE;
		else if (coll | ~en)
			ctrl2_ff <= RST_BYTE;
		else if (wr_c2 & ~port_busy)
			ctrl2_ff <= wd & ~(8'h01 << C2_STAT);
		else begin
			if (stop_ok)
				ctrl2_ff[C2_PEN] <= 1'b0;
			if (rx_done)
				ctrl2_ff[C2_RECEIVE_ENABLE] <= 1'b0;
			if (tx_done)
				ctrl2_ff[C2_STAT] <= sda_in;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cnt_ff <= 9'h000;
			run_ff <= 1'b0;
		end else if (brg_load) begin
			cnt_ff <= load_val;
			run_ff <= 1'b1;
		end else if (brg_stop | coll | ~en) begin
			run_ff <= 1'b0;
		end else if (run_ff) begin
			cnt_ff <= cnt_ff - 9'h001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			state_ff <= S_IDLE;
		else
			state_ff <= nxt_state;
	end

	// line drivers hold their level in idle so SCL parks where it was
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			scl_low_ff <= 1'b0;
			sda_low_ff <= 1'b0;
		end else if (coll | ~en) begin
			scl_low_ff <= 1'b0;
			sda_low_ff <= 1'b0;
		end else if (tx_go) begin
			scl_low_ff <= 1'b1;
			sda_low_ff <= ~wd[7];
		end else if (rx_go) begin
			scl_low_ff <= 1'b1;
			sda_low_ff <= 1'b0;
		end else if (stp_go) begin
			scl_low_ff <= 1'b1;
			sda_low_ff <= 1'b1;
		end else if (state_ff == S_BIT_LOW & brg_to) begin
			scl_low_ff <= 1'b0;
		end else if (bit_done) begin
			// the last fall (ninth when sending, eighth when receiving) parks SCL low so the bus stays ours
			scl_low_ff <= 1'b1;
			sda_low_ff <= ~rx_ff & ~ack_next & ~last_bit & ~nxt_shift[7];
		end else if (state_ff == S_STP_LOW & brg_to) begin
			scl_low_ff <= 1'b0;
		end else if (state_ff == S_STP_HIGH & brg_to) begin
			sda_low_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			shift_ff <= RST_BYTE;
			bits_ff  <= 4'h0;
			rx_ff    <= 1'b0;
		end else if (tx_go) begin
			shift_ff <= wd;
			bits_ff  <= TX_BITS;
			rx_ff    <= 1'b0;
		end else if (rx_go) begin
			bits_ff  <= RX_BITS;
			rx_ff    <= 1'b1;
		end else if (bit_done) begin
			shift_ff <= nxt_shift;
			bits_ff  <= bits_ff - 4'h1;
		end
	end

	// buffer: refused writes leave it untouched
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			buffer_ff  <= RST_BYTE;
			full_ff    <= 1'b0;
			tx_busy_ff <= 1'b0;
		end else begin
			if (tx_go)
				buffer_ff <= wd;
			else if (rx_done)
				buffer_ff <= nxt_shift;
			if (tx_go | rx_done)
				full_ff <= 1'b1;
			else if (bit_done & ack_next | coll | rd_buf & ~tx_busy_ff)
				full_ff <= 1'b0;
			if (tx_go)
				tx_busy_ff <= 1'b1;
			else if (tx_done | coll | ~en)
				tx_busy_ff <= 1'b0;
		end
	end

	// bus monitor: start and stop seen, byte kind, direction, address update
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			scl_q_ff      <= 1'b1;
			sda_q_ff      <= 1'b1;
			start_seen_ff <= 1'b0;
			stop_seen_ff  <= 1'b0;
			first_ff      <= 1'b0;
			data_ff       <= 1'b0;
			rw_ff         <= 1'b0;
			ua_ff         <= 1'b0;
		end else begin
			scl_q_ff <= scl_in;
			sda_q_ff <= sda_in;
			if (~en) begin
				start_seen_ff <= 1'b0;
				stop_seen_ff  <= 1'b0;
			end else if (start_det) begin
				start_seen_ff <= 1'b1;
				stop_seen_ff  <= 1'b0;
			end else if (stop_det | coll_sda == 1'b0 & stop_ok) begin
				start_seen_ff <= 1'b0;
				stop_seen_ff  <= 1'b1;
			end
			if (start_det)
				first_ff <= 1'b1;
			else if (bit_done & ack_next | rx_done)
				first_ff <= 1'b0;
			if (bit_done & ack_next | rx_done)
				data_ff <= ~first_ff;
			if (start_det | stop_det | tx_done & sda_in)
				rw_ff <= 1'b0;
			else if (bit_done & ack_next & first_ff)
				rw_ff <= shift_ff[6];
			if (ten_bit & first_ff & bit_done & ack_next)
				ua_ff <= 1'b1;
			else if (wr_rel)
				ua_ff <= 1'b0;
		end
	end

	// checks
	logic [8:0] low_len_ff;
	always_ff @(posedge ref_clk) begin
		if (!reset_n || state_ff != S_BIT_LOW)
			low_len_ff <= 9'h001;
		else
			low_len_ff <= low_len_ff + 9'h001;
	end

	sequence s_stop_tail;
		state_ff == S_STP_END && brg_to && en;
	endsequence

	property p_coll_sda;
		@(posedge ref_clk) disable iff (!reset_n)
		coll_sda && en |=> irq_ff[FL_COLL] && state_ff == S_IDLE
			&& !stop_enable && !sda_low_ff && !scl_low_ff;
	endproperty
	a_coll_sda: assert property (p_coll_sda)
		else $error("sda low after stop release not flagged");

	property p_coll_scl;
		@(posedge ref_clk) disable iff (!reset_n)
		state_ff == S_STP_HIGH && !scl_in && en
			|=> irq_ff[FL_COLL] && state_ff == S_IDLE;
	endproperty
	a_coll_scl: assert property (p_coll_scl)
		else $error("scl low during stop not flagged");

	property p_stop_load;
		@(posedge ref_clk) disable iff (!reset_n)
		state_ff == S_STP_SCL && scl_in && en
			|=> state_ff == S_STP_HIGH && cnt_ff == phase_len(reload_ff);
	endproperty
	a_stop_load: assert property (p_stop_load)
		else $error("generator not loaded on scl high in stop");

	property p_buf_start;
		@(posedge ref_clk) disable iff (!reset_n)
		tx_go && en ##1 1'b1 |-> run_ff && full_ff
			##1 cnt_ff == phase_len(reload_ff) - 9'h001;
	endproperty
	a_buf_start: assert property (p_buf_start)
		else $error("buffer write did not start generator");

	property p_hold;
		@(posedge ref_clk) disable iff (!reset_n)
		(state_ff == S_IDLE && en && !tx_go && !rx_go && !stp_go)[*2]
			|-> $stable(pads.scl_oe_n) && !run_ff;
	endproperty
	a_hold: assert property (p_hold)
		else $error("scl or generator moved while idle");

	property p_low_len;
		@(posedge ref_clk) disable iff (!reset_n)
		state_ff == S_BIT_LOW && nxt_state == S_BIT_WAIT
			|-> low_len_ff == phase_len(reload_ff) + 9'h001;
	endproperty
	a_low_len: assert property (p_low_len)
		else $error("scl low phase length wrong");

	property p_write_collision;
		@(posedge ref_clk) disable iff (!reset_n)
		wr_buf && in_stop |=> write_collision_ff && $stable(buffer_ff);
	endproperty
	a_write_collision: assert property (p_write_collision)
		else $error("write during stop not refused");

	property p_stop_end;
		@(posedge ref_clk) disable iff (!reset_n)
		s_stop_tail |=> !stop_enable && irq_ff[FL_PORT] && stop_seen_ff
			&& !sda_low_ff;
	endproperty
	a_stop_end: assert property (p_stop_end)
		else $error("clean stop did not finish correctly");

	property p_disable;
		@(posedge ref_clk) disable iff (!reset_n)
		!en |=> !start_seen_ff && !stop_seen_ff;
	endproperty
	a_disable: assert property (p_disable)
		else $error("start or stop seen survives disable");

	property p_bf_ack;
		@(posedge ref_clk) disable iff (!reset_n)
		bit_done && ack_next && !rd_buf |=> !full_ff && data_ff == !$past(first_ff);
	endproperty
	a_bf_ack: assert property (p_bf_ack)
		else $error("buffer full or data flag wrong at ack bit");
endmodule

// file: testbench/i2c_bus_model.sv
// far side of the serial port: pull-ups, other masters, a simple sender
// assumes pads.*_out are tied low, so a low enable means the wire is pulled
`timescale 1ns/1ps
module i2c_bus_model
	import sync_serial_pkg::*;
(
	input  wire logic                 ref_clk,
	input  wire sync_serial_pkg::pad_out_t pads,
	input  wire logic                 sda_hold,
	input  wire logic                 scl_hold,
	input  wire logic                 rx_en,
	input  wire logic [7:0]           rx_byte,
	output logic                      scl_in,
	output logic                      sda_in
);
	logic       scl_d;
	logic       low_seen;
	logic       rise_seen;
	logic [3:0] idx;
	wire        rx_low;
	// data is only put out once SCL has been low, so no false start appears
	assign rx_low = rx_en & low_seen & (idx < 4'h8) &
		~rx_byte[3'h7 - idx[2:0]];
	// released lines float to the pull-up level
	assign scl_in = pads.scl_oe_n & ~scl_hold;
	assign sda_in = pads.sda_oe_n & ~sda_hold & ~rx_low;
	always_ff @(posedge ref_clk) begin
		scl_d <= scl_in;
		if (!rx_en) begin
			low_seen  <= 1'b0;
			rise_seen <= 1'b0;
			idx       <= 4'h0;
		end else begin
			if (!scl_in)
				low_seen <= 1'b1;
			if (low_seen & scl_in & ~scl_d)
				rise_seen <= 1'b1;
			// next bit only while SCL is low
			if (rise_seen & scl_d & ~scl_in)
				idx <= idx + 4'h1;
		end
	end
endmodule

// file: testbench/sync_serial_port_tb_top.sv
// self-checking bench for the serial port: registers, transfers, stop
// assumes the bus model on the wires; bus accesses wait for waitrequest
`timescale 1ns/1ps
module sync_serial_port_tb_top;
	import sync_serial_pkg::*;
	logic        ref_clk;
	logic        reset_n;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        scl_in;
	logic        sda_in;
	pad_out_t    pads;
	pin_cfg_t    pin_cfg;
	logic        port_busy;
	logic        sda_hold;
	logic        scl_hold;
	logic        rx_en;
	logic [7:0]  rx_byte;
	logic        cap_clr;
	logic        scl_d;
	logic [8:0]  cap_sh;
	int          cap_cnt;
	int          fall_cnt;
	int          per;
	int          mismatches;
	int          cmp_count;
	logic [7:0]  cfg_tab [4][3];

	sync_serial_port dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.scl_in(scl_in), .sda_in(sda_in), .pads(pads), .pin_cfg(pin_cfg),
		.port_busy(port_busy));
	i2c_bus_model bus (.ref_clk(ref_clk), .pads(pads), .sda_hold(sda_hold),
		.scl_hold(scl_hold), .rx_en(rx_en), .rx_byte(rx_byte),
		.scl_in(scl_in), .sda_in(sda_in));

	always #5 ref_clk = ~ref_clk;

	// bit capture at SCL rise and SCL period between falls
	always @(posedge ref_clk) begin
		scl_d <= scl_in;
		if (cap_clr)
			cap_cnt <= 0;
		else if (scl_in & ~scl_d) begin
			cap_sh  <= {cap_sh[7:0], sda_in};
			cap_cnt <= cap_cnt + 1;
		end
		if (~scl_in & scl_d) begin
			per      <= fall_cnt;
			fall_cnt <= 1;
		end else
			fall_cnt <= fall_cnt + 1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one Avalon access; held until waitrequest is seen low at the edge
	task automatic bus_op(input logic wr, input logic [4:0] a,
		input logic [7:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address   <= a;
		avs_writedata <= {24'h000000, d};
		avs_write     <= wr;
		avs_read      <= ~wr;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 100)
			chk(32'h0000DEAD, 32'h00000000);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus_op(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] q;
		bus_op(1'b0, a, 8'h00, q);
		chk(q & m, exp);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		repeat (2) @(posedge ref_clk);
		while (port_busy !== 1'b0 && n < 2000) begin
			@(posedge ref_clk);
			n++;
		end
		chk(32'(port_busy), 32'h0);
	endtask

	task automatic end_of_test();
		if (mismatches == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#200000;
		mismatches++;
		end_of_test();
	end

	initial begin
		ref_clk = 1'b0;
		reset_n = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		sda_hold = 1'b0;
		scl_hold = 1'b0;
		rx_en = 1'b0;
		rx_byte = 8'h00;
		cap_clr = 1'b1;
		cap_sh = 9'h000;
		fall_cnt = 0;
		per = 0;
		mismatches = 0;
		cmp_count = 0;
		// ctrl1, status, expected {slew, smbus, sample_end, tx_idle_edge}
		cfg_tab = '{'{8'h00, 8'hC0, 8'h03}, '{8'h00, 8'h00, 8'h00},
			'{8'h28, 8'hC0, 8'h04}, '{8'h28, 8'h00, 8'h08}};
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(OFS_STATUS, 32'hFFFFFFFF, 32'h0);
		rd(5'h02, 32'hFFFFFFFF, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CTRL1, cfg_tab[i][0]);
			wr(OFS_STATUS, cfg_tab[i][1]);
			rd(OFS_STATUS, 32'hC0, 32'(cfg_tab[i][1]));
			chk(32'(pin_cfg), 32'(cfg_tab[i][2]));
		end
		// another master makes a start, then a stop on the idle bus
		sda_hold <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd(OFS_STATUS, 32'h18, 32'h08);
		sda_hold <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rd(OFS_STATUS, 32'h18, 32'h10);
		wr(OFS_RELOAD, 8'h03);
		cap_clr <= 1'b0;
		wr(OFS_BUFFER, 8'hA5);
		rd(OFS_STATUS, 32'h05, 32'h05);
		chk(32'(port_busy), 32'h1);
		wait_idle();
		chk(32'(cap_sh[8:1]), 32'hA5);
		chk(32'(cap_cnt), 32'd9);
		chk(32'(per), 32'd16);
		rd(OFS_STATUS, 32'h25, 32'h00);
		repeat (40) @(posedge ref_clk);
		chk(32'(scl_in), 32'h0);
		rd(OFS_FLAGS, 32'h03, 32'h01);
		wr(OFS_FLAGS, 8'h03);
		rd(OFS_FLAGS, 32'h03, 32'h00);
		// clean stop, with a buffer write thrown in while it runs
		wr(OFS_CTRL2, 8'h04);
		wr(OFS_BUFFER, 8'h5A);
		rd(OFS_CTRL1, 32'h80, 32'h80);
		wait_idle();
		rd(OFS_STATUS, 32'h10, 32'h10);
		rd(OFS_CTRL2, 32'h04, 32'h00);
		rd(OFS_FLAGS, 32'h03, 32'h01);
		chk(32'({scl_in, sda_in}), 32'h3);
		wr(OFS_CTRL1, 8'h28);
		rd(OFS_CTRL1, 32'h80, 32'h00);
		rd(OFS_BUFFER, 32'hFF, 32'hA5);
		wr(OFS_FLAGS, 8'h03);
		// receive one byte from the model
		rx_byte <= 8'h3C;
		rx_en <= 1'b1;
		wr(OFS_CTRL2, 8'h08);
		wait_idle();
		rx_en <= 1'b0;
		rd(OFS_STATUS, 32'h21, 32'h21);
		rd(OFS_BUFFER, 32'hFF, 32'h3C);
		rd(OFS_STATUS, 32'h01, 32'h00);
		wr(OFS_FLAGS, 8'h03);
		// stop while another master keeps SDA low
		sda_hold <= 1'b1;
		wr(OFS_CTRL2, 8'h04);
		wait_idle();
		rd(OFS_FLAGS, 32'h02, 32'h02);
		rd(OFS_CTRL2, 32'h04, 32'h00);
		chk(32'({pads.scl_oe_n, pads.sda_oe_n}), 32'h3);
		sda_hold <= 1'b0;
		wr(OFS_FLAGS, 8'h03);
		wr(OFS_BUFFER, 8'h00);
		wait_idle();
		wr(OFS_FLAGS, 8'h03);
		// stop where another master pulls SCL low after it rose
		wr(OFS_CTRL2, 8'h04);
		for (int n = 0; n < 300 && scl_in !== 1'b1; n++)
			@(posedge ref_clk);
		repeat (2) @(posedge ref_clk);
		scl_hold <= 1'b1;
		repeat (2) @(posedge ref_clk);
		scl_hold <= 1'b0;
		wait_idle();
		rd(OFS_FLAGS, 32'h02, 32'h02);
		rd(OFS_CTRL2, 32'h04, 32'h00);
		wr(OFS_CTRL1, 8'h08);
		rd(OFS_STATUS, 32'h18, 32'h00);
		end_of_test();
	end
endmodule
